// ===== src/cfu_flag_unit.sv
// Condition flag update unit of the instruction processor.
// Assumes one instruction strobe per cycle at most, operands already
// fetched; the result word is written back by the caller.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "cfu_consts.svh"

module cfu_flag_unit
  import cfu_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Instruction issue
  input wire logic instr_valid,
  input wire logic [7:0] instr_op,
  input wire logic [15:0] operand_a,
  input wire logic [15:0] operand_b,
  input wire logic operand_bad,
  input wire logic shift_carry_valid,
  input wire logic shift_carry_bit,
  // Execution result
  output logic instr_executed,
  output logic [15:0] result_word,
  output logic [15:0] flag_word,
  output logic bad_input_flag,
  output logic carry_flag,
  output logic less_flag,
  output logic same_flag,
  output logic greater_flag,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // Interrupt
  output logic irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    cfu_flags_t flags;
    logic [2:0] status;
    logic [2:0] mask;
    logic [15:0] result;
    logic executed;
    logic [15:0] skip_count;
    logic [15:0] rdata;
  } cfu_state_t;

  cfu_state_t state_reg;
  cfu_state_t state_next;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Which flags each class may update
  function automatic cfu_upd_t upd_mask(input logic [7:0] op);
    cfu_upd_t m;
    m = '0;
    unique case (op)
      `CFU_OP_ADD, `CFU_OP_SUB: begin
        m.er = 1'b1;
        m.cy = 1'b1;
        m.eq = 1'b1;
      end
      `CFU_OP_AND, `CFU_OP_OR, `CFU_OP_COPY, `CFU_OP_ICOPY: begin
        m.er = 1'b1;
        m.eq = 1'b1;
      end
      `CFU_OP_CMP: begin
        m.er = 1'b1;
        m.lt = 1'b1;
        m.eq = 1'b1;
        m.gt = 1'b1;
      end
      `CFU_OP_STEP, `CFU_OP_SNEXT, `CFU_OP_SHIFT, `CFU_OP_DRUM,
      `CFU_OP_FCNT, `CFU_OP_RCMP: begin
        m.er = 1'b1;
      end
      default: begin
        m = '0;
      end
    endcase
    return m;
  endfunction : upd_mask

  // Four-digit decimal add or subtract with carry/borrow
  function automatic logic [16:0] bcd_arith(input logic [15:0] a,
                                            input logic [15:0] b,
                                            input logic cin,
                                            input logic sub);
    logic [4:0] d;
    logic c;
    logic [15:0] r;
    c = cin;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      if (sub) begin
        d = {1'b0, a[i*4 +: 4]} - {1'b0, b[i*4 +: 4]} - {4'h0, c};
        c = d[4];
        if (c) begin
          d = d + 5'h0a;
        end
      end else begin
        d = {1'b0, a[i*4 +: 4]} + {1'b0, b[i*4 +: 4]} + {4'h0, c};
        c = (d > 5'h09);
        if (c) begin
          d = d - 5'h0a;
        end
      end
      r[i*4 +: 4] = d[3:0];
    end
    return {c, r};
  endfunction : bcd_arith

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    cfu_upd_t upd;
    logic [16:0] sum;
    logic [15:0] res;
    logic [2:0] ev;
    upd = upd_mask(instr_op);
    sum = '0;
    res = '0;
    ev = '0;
    state_next = state_reg;
    state_next.executed = 1'b0;
    state_next.rdata = '0;

    if (instr_valid) begin
      if (instr_op == `CFU_OP_END) begin
        state_next.flags = `CFU_FLAGS_RST;
        state_next.executed = 1'b1;
      end else if (state_reg.flags.er && upd.er) begin
        // Skipped; flags hold for the rest of the scan
        state_next.skip_count = state_reg.skip_count + 16'h0001;
        ev[1] = 1'b1;
      end else if (instr_op == `CFU_OP_CLC) begin
        if (!state_reg.flags.er) begin
          state_next.flags.cy = 1'b0;
        end
        state_next.executed = 1'b1;
      end else begin
        state_next.executed = 1'b1; // timers still run
        unique case (instr_op)
          `CFU_OP_ADD, `CFU_OP_SUB: begin
            sum = bcd_arith(operand_a, operand_b, state_reg.flags.cy,
                            instr_op == `CFU_OP_SUB);
            res = sum[15:0];
          end
          `CFU_OP_AND: res = operand_a & operand_b;
          `CFU_OP_OR: res = operand_a | operand_b;
          `CFU_OP_COPY: res = operand_a;
          `CFU_OP_ICOPY: res = ~operand_a;
          default: res = state_reg.result;
        endcase
        if (upd.er) begin
          state_next.flags.er = operand_bad;
          ev[0] = operand_bad;
        end
        // Other flags only move on clean operands
        if (!operand_bad && !state_reg.flags.er) begin
          state_next.result = res;
          if (upd.cy) begin
            state_next.flags.cy = sum[16];
          end
          if (upd.eq && !upd.gt) begin
            state_next.flags.eq = (res == 16'h0000);
          end
          if (upd.gt) begin
            state_next.flags.gt = operand_a > operand_b;
            state_next.flags.lt = operand_a < operand_b;
            state_next.flags.eq = operand_a == operand_b;
          end
        end
      end
      // Shift chain reports its bit through carry when allowed
      if (instr_op == `CFU_OP_SHIFT && shift_carry_valid &&
          !state_reg.flags.er && !operand_bad) begin
        state_next.flags.cy = shift_carry_bit;
      end
      ev[2] = (instr_op == `CFU_OP_END);
    end

    // Register writes; a new event beats the write-one clear
    if (reg_write && reg_addr == `CFU_ADDR_MASK) begin
      state_next.mask = reg_wdata[2:0];
    end
    if (reg_write && reg_addr == `CFU_ADDR_STATUS) begin
      state_next.status = state_reg.status & ~reg_wdata[2:0];
    end
    if (reg_write && reg_addr == `CFU_ADDR_COUNT) begin
      state_next.skip_count = '0;
    end
    state_next.status = state_next.status | ev;

    if (reg_read) begin
      unique case (reg_addr)
        `CFU_ADDR_FLAGS: state_next.rdata = flag_word;
        `CFU_ADDR_STATUS: state_next.rdata = {13'h0000, state_reg.status};
        `CFU_ADDR_MASK: state_next.rdata = {13'h0000, state_reg.mask};
        `CFU_ADDR_COUNT: state_next.rdata = state_reg.skip_count;
        default: state_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign flag_word = {state_reg.flags, 11'h000};
  assign bad_input_flag = state_reg.flags.er;
  assign carry_flag = state_reg.flags.cy;
  assign less_flag = state_reg.flags.lt;
  assign same_flag = state_reg.flags.eq;
  assign greater_flag = state_reg.flags.gt;
  assign instr_executed = state_reg.executed;
  assign result_word = state_reg.result;
  assign reg_rdata = state_reg.rdata;
  assign irq = |(state_reg.status & state_reg.mask);

endmodule : cfu_flag_unit

// ===== include/cfu_consts.svh
// Constants for the condition flag update unit: flag bit positions,
// opcodes, register offsets and reset values.
// Assumes a single 100 MHz clock and a plain strobe register port.
`ifndef CFU_CONSTS_SVH
`define CFU_CONSTS_SVH

// ----------------------------------------
// Flag bits in word 03
// ----------------------------------------
`define CFU_BIT_ERR 4'hb
`define CFU_BIT_CY 4'hc
`define CFU_BIT_LT 4'hd
`define CFU_BIT_EQ 4'he
`define CFU_BIT_GT 4'hf

// ----------------------------------------
// Function codes
// ----------------------------------------
`define CFU_OP_END 8'h01
`define CFU_OP_STEP 8'h04
`define CFU_OP_SNEXT 8'h05
`define CFU_OP_MDLY 8'h20
`define CFU_OP_FDLY 8'h21
`define CFU_OP_ADLY 8'h22
`define CFU_OP_DRUM 8'h23
`define CFU_OP_FCNT 8'h24
`define CFU_OP_ANA1 8'h25
`define CFU_OP_ANA2 8'h26
`define CFU_OP_COPY 8'h30
`define CFU_OP_ICOPY 8'h31
`define CFU_OP_CMP 8'h32
`define CFU_OP_SHIFT 8'h33
`define CFU_OP_RCMP 8'h34
`define CFU_OP_ADD 8'h40
`define CFU_OP_SUB 8'h41
`define CFU_OP_AND 8'h42
`define CFU_OP_OR 8'h43
`define CFU_OP_CLC 8'h44

// ----------------------------------------
// Registers
// ----------------------------------------
`define CFU_ADDR_FLAGS 4'h0
`define CFU_ADDR_STATUS 4'h1
`define CFU_ADDR_MASK 4'h2
`define CFU_ADDR_COUNT 4'h3
`define CFU_FLAGS_RST 5'h00
`define CFU_MASK_RST 3'h0

`endif

// ===== include/cfu_pkg.sv
// Types for the condition flag update unit.
// Assumes cfu_consts.svh is on the include path.
package cfu_pkg;

  // Flag set, packed in word 03 order from bit 11 upward
  typedef struct packed {
    logic gt;
    logic eq;
    logic lt;
    logic cy;
    logic er;
  } cfu_flags_t;

  // Which flags an instruction class may touch
  typedef struct packed {
    logic gt;
    logic eq;
    logic lt;
    logic cy;
    logic er;
  } cfu_upd_t;

endpackage : cfu_pkg

// ===== tb/cfu_flag_asserts.sv
// Port checker for the condition flag unit.
// Assumes a bind onto cfu_flag_unit; one clock domain.
`timescale 1ns/1ps
`include "cfu_consts.svh"
module cfu_flag_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Issue
  input wire logic instr_valid,
  input wire logic [7:0] instr_op,
  input wire logic [15:0] operand_a,
  input wire logic [15:0] operand_b,
  input wire logic operand_bad,
  // Results
  input wire logic instr_executed,
  input wire logic [15:0] result_word,
  input wire logic [15:0] flag_word,
  input wire logic bad_input_flag,
  input wire logic carry_flag,
  input wire logic less_flag,
  input wire logic same_flag,
  input wire logic greater_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire [4:0] f = {greater_flag, same_flag, less_flag, carry_flag,
    bad_input_flag};
  wire go = instr_valid && !bad_input_flag;
  // Instructions that update the error flag
  wire er_op = instr_op inside {8'h04, 8'h05, 8'h23, 8'h24, 8'h33, 8'h34,
    8'h30, 8'h31, 8'h32, 8'h40, 8'h41, 8'h42, 8'h43};
  wire tmr_op = !er_op && instr_op != 8'h01 && instr_op != 8'h44;
  flag_map_a: assert property (flag_word == {f, 11'h000})
    else $error("flag word layout wrong");
  end_clear_a: assert property (instr_valid &&
    instr_op == 8'h01 |=> f == 5'h00) else $error("end left a flag set");
  bad_set_a: assert property (go && operand_bad && er_op |=>
    bad_input_flag && $stable(f[4:1])) else $error("bad operand missed");
  skip_a: assert property (instr_valid && bad_input_flag &&
    er_op |=> !instr_executed && $stable(f))
    else $error("op ran under error");
  clc_a: assert property (go && instr_op == 8'h44 |=>
    !carry_flag && $stable({f[4:2], f[0]}))
    else $error("carry clear wrong");
  timer_a: assert property (instr_valid && tmr_op |=>
    instr_executed && $stable(f)) else $error("timer touched flags");
  cmp_a: assert property (go && !operand_bad &&
    instr_op == 8'h32 |=> $onehot(f[4:2]) && $stable(carry_flag) &&
    greater_flag == ($past(operand_a) > $past(operand_b)))
    else $error("compare wrong");
  zero_a: assert property (go && !operand_bad &&
    instr_op inside {8'h30, 8'h31, 8'h40, 8'h41, 8'h42, 8'h43} |=>
    same_flag == (result_word == 16'h0000)) else $error("zero flag wrong");
  step_a: assert property (go && instr_op inside {8'h04, 8'h05,
    8'h23, 8'h24, 8'h34} |=> $stable(f[4:1]))
    else $error("step touched flags");
  cover property (go && instr_op == 8'h32);
  cover property (instr_valid && bad_input_flag && er_op);
  cover property (instr_valid && instr_op == 8'h01);
endmodule : cfu_flag_asserts

bind cfu_flag_unit cfu_flag_asserts u_chk (.clock, .rst, .instr_valid,
  .instr_op, .operand_a, .operand_b, .operand_bad, .instr_executed,
  .result_word, .flag_word, .bad_input_flag, .carry_flag, .less_flag,
  .same_flag, .greater_flag);

// ===== tb/cfu_flag_unit_tb_top.sv
// Directed self-checking bench for the condition flag unit.
// Assumes the package and constants header are compiled first.
`timescale 1ns/1ps
`include "cfu_consts.svh"
module cfu_flag_unit_tb_top;
  import cfu_pkg::*;
  logic clock, rst, instr_valid, operand_bad, instr_executed, irq;
  logic shift_carry_valid, shift_carry_bit, reg_write, reg_read;
  logic bad_input_flag, carry_flag, less_flag, same_flag, greater_flag;
  logic [7:0] instr_op;
  logic [3:0] reg_addr;
  logic [15:0] operand_a, operand_b, result_word, flag_word;
  logic [15:0] reg_wdata, reg_rdata;
  int mismatches = 0, total_checks = 0, cycles = 0;
  wire [15:0] fl = {11'h000, greater_flag, same_flag, less_flag,
    carry_flag, bad_input_flag};

  cfu_flag_unit dut (.clock, .rst, .instr_valid, .instr_op, .operand_a,
    .operand_b, .operand_bad, .shift_carry_valid, .shift_carry_bit,
    .instr_executed, .result_word, .flag_word, .bad_input_flag,
    .carry_flag, .less_flag, .same_flag, .greater_flag, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Generous ceiling; the directed run needs about 90 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, g);
    total_checks++;
    if (e !== g) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Flags given as {gt, eq, lt, cy, er}
  task automatic run(input logic [7:0] c, input logic [15:0] a, b,
      input logic [4:0] f, input logic [15:0] r, input logic bad = 1'b0,
      input logic [1:0] sc = 2'b00, input logic ex = 1'b1);
    @(posedge clock);
    {instr_valid, instr_op, operand_a, operand_b} <= {1'b1, c, a, b};
    {operand_bad, shift_carry_valid, shift_carry_bit} <= {bad, sc};
    @(posedge clock);
    {instr_valid, operand_bad, shift_carry_valid} <= 3'b000;
    #1;
    chk("flags", {11'h000, f}, fl);
    // Result and execution of a bad-operand op are left open
    if (!bad) begin
      chk("result", r, result_word);
      chk("executed", {15'h0000, ex}, {15'h0000, instr_executed});
    end
  endtask : run

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock);
    {reg_read, reg_addr} <= {1'b1, a};
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk("register", e, reg_rdata);
  endtask : rd

  task automatic t_cmp;
    run(8'h32, 16'h0003, 16'h0005, 5'b00100, 16'h0000);
    run(8'h32, 16'h0005, 16'h0005, 5'b01000, 16'h0000);
    run(8'h32, 16'h0005, 16'h0003, 5'b10000, 16'h0000);
  endtask : t_cmp

  task automatic t_arith;
    run(8'h44, 16'h0000, 16'h0000, 5'b10000, 16'h0000);
    run(8'h40, 16'h0009, 16'h0001, 5'b10000, 16'h0010);
    run(8'h40, 16'h9999, 16'h0001, 5'b11010, 16'h0000);
    run(8'h40, 16'h0000, 16'h0000, 5'b10000, 16'h0001);
    run(8'h41, 16'h0000, 16'h0001, 5'b10010, 16'h9999);
  endtask : t_arith

  task automatic t_logic;
    logic [7:0] tm [5] = '{8'h20, 8'h21, 8'h22, 8'h25, 8'h26};
    logic [7:0] st [3] = '{8'h05, 8'h23, 8'h34};
    run(8'h30, 16'h0000, 16'h0000, 5'b11010, 16'h0000);
    run(8'h31, 16'hffff, 16'h0000, 5'b11010, 16'h0000);
    run(8'h42, 16'h00f0, 16'h0f00, 5'b11010, 16'h0000);
    run(8'h43, 16'h0001, 16'h0000, 5'b10010, 16'h0001);
    run(8'h44, 16'h0000, 16'h0000, 5'b10000, 16'h0001);
    run(8'h33, 16'h0000, 16'h0000, 5'b10010, 16'h0001,
      1'b0, 2'b11);
    run(8'h04, 16'h0000, 16'h0000, 5'b10010, 16'h0001);
    foreach (st[i]) run(st[i], 16'h0, 16'h0, 5'h12, 16'h1);
    foreach (tm[i]) run(tm[i], 16'h0, 16'h0, 5'h12, 16'h1);
  endtask : t_logic

  task automatic t_err;
    run(8'h30, 16'h0000, 16'h0000, 5'b10011, 16'h0001, 1'b1);
    run(8'h40, 16'h0001, 16'h0001, 5'b10011, 16'h0001,
      1'b0, 2'b00, 1'b0);
    run(8'h20, 16'h0000, 16'h0000, 5'b10011, 16'h0001);
    run(8'h44, 16'h0000, 16'h0000, 5'b10011, 16'h0001);
    chk("flag word", 16'h9800, flag_word);
    wr(4'h0, 16'hffff);
    rd(4'h0, 16'h9800);
    rd(4'h1, 16'h0003);
    rd(4'h3, 16'h0001);
    rd(4'hf, 16'h0000);
    wr(4'h2, 16'h0002);
    rd(4'h2, 16'h0002);
    chk("irq", 16'h0001, {15'h0000, irq});
    wr(4'h1, 16'h0002);
    rd(4'h1, 16'h0001);
    chk("irq", 16'h0000, {15'h0000, irq});
    wr(4'h3, 16'h0000);
    rd(4'h3, 16'h0000);
    run(8'h01, 16'h0000, 16'h0000, 5'b00000, 16'h0001);
    rd(4'h1, 16'h0005);
  endtask : t_err

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  initial begin
    {rst, instr_valid, instr_op, operand_a, operand_b, operand_bad} = '1;
    {instr_valid, instr_op, operand_a, operand_b, operand_bad} = '0;
    {shift_carry_valid, shift_carry_bit, reg_write, reg_read} = '0;
    {reg_addr, reg_wdata} = '0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_cmp();
    t_arith();
    t_logic();
    t_err();
    results();
  end
endmodule : cfu_flag_unit_tb_top
